// [hdl/hub_strap_decode.sv]
// strap latch, decode, pin function mux and port control pins with apb access
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module hub_strap_decode #(
    parameter int SETTLE_CYCLES = hub_strap_pkg::SETTLE_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic chip_reset_n_in,
    input wire logic [5:0] port_dplus_disable_strap_in,
    input wire logic [5:0] port_dminus_disable_strap_in,
    input wire logic [2:0] fixed_port_count_strap_in,
    input wire logic [2:0] charging_port_count_strap_in,
    input wire logic [2:0] mode1_strap_in,
    input wire logic [2:0] mode2_strap_in,
    input wire logic [5:0] port_power_control_in,
    input wire logic microphone_detect_in,
    output logic [5:0] port_power_control_out,
    output logic [5:0] port_power_control_oe_out,
    output logic [2:0] superspeed_power_control_oe_out,
    output logic [5:0] port_disabled_out,
    output logic [5:0] superspeed_disabled_out,
    output logic [5:0] fixed_port_mask_out,
    output logic [5:0] charging_port_mask_out,
    output logic [5:0] overcurrent_out,
    output logic mode_reserved_out,
    output logic microphone_detect_out,
    output logic straps_latched_out,
    output logic [hub_strap_pkg::NUM_PF*hub_strap_pkg::FN_W-1:0] pin_function_out
);
    localparam int PFW = hub_strap_pkg::NUM_PF * hub_strap_pkg::FN_W;
    localparam int FW = hub_strap_pkg::FN_W;
    localparam int MIC_OFS = (hub_strap_pkg::MIC_PIN - hub_strap_pkg::PF_FIRST) * FW;
    localparam int SYNC_W = 32;
    localparam int LAT_MIN = 1;
    localparam int LAT_MAX = 8;

    typedef struct packed {
        logic pending;
        logic [2:0] settle;
        logic capture;
        logic [5:0] dplus;
        logic [5:0] dminus;
        logic [5:0] port_dis;
        logic [5:0] ss_dis;
        logic [5:0] fixed_mask;
        logic [5:0] charge_mask;
        logic mode_rsv;
        logic [5:0] host_dis;
        logic [PFW-1:0] pin_fn;
        logic [5:0] ctl_oe;
        logic [2:0] ss_oe;
        logic [5:0] oc;
        logic mic;
        hub_strap_pkg::apb_rsp_type rsp;
    } state_type;

    state_type st;
    state_type next_st;
    hub_strap_pkg::apb_req_type req;
    logic [SYNC_W-1:0] sync_q;
    logic [5:0] dplus_s;
    logic [5:0] dminus_s;
    logic [2:0] fixed_s;
    logic [2:0] charge_s;
    logic [2:0] mode1_s;
    logic [2:0] mode2_s;
    logic ext_ok;
    logic [5:0] ctl_n_s;
    logic mic_s;
    logic [5:0] eff_dis;
    logic [5:0] ctl_fn_ok;
    logic [5:0] ss_fn_ok;

    initial begin
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 7) $error("SETTLE_CYCLES must be 1 to 7");
    end

    assign req = '{paddr: paddr_in, psel: psel_in, penable: penable_in,
                   pwrite: pwrite_in, pwdata: pwdata_in};

    strap_sync #(
        .WIDTH(SYNC_W)
    ) pin_sync (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .pin_in({microphone_detect_in, port_power_control_in, chip_reset_n_in,
                 mode2_strap_in, mode1_strap_in, charging_port_count_strap_in,
                 fixed_port_count_strap_in, port_dminus_disable_strap_in,
                 port_dplus_disable_strap_in}),
        .level_out(sync_q)
    );

    assign {mic_s, ctl_n_s, ext_ok, mode2_s, mode1_s, charge_s, fixed_s, dminus_s, dplus_s} = sync_q;

    assign eff_dis = st.port_dis | st.host_dis;

    genvar gp;
    generate
        for (gp = 0; gp < hub_strap_pkg::NUM_PORTS; gp++) begin : g_port
            localparam int CP = (hub_strap_pkg::power_pin(gp) - hub_strap_pkg::PF_FIRST) * FW;
            localparam int SP = (hub_strap_pkg::ss_pin(gp) - hub_strap_pkg::PF_FIRST) * FW;
            assign ctl_fn_ok[gp] = st.pin_fn[CP +: FW] == hub_strap_pkg::FN_POWER_CTL;
            if (gp >= 2 && gp <= 4) begin : g_ss
                assign ss_fn_ok[gp] = st.pin_fn[SP +: FW] == hub_strap_pkg::FN_POWER_CTL;
            end else begin : g_no_ss
                assign ss_fn_ok[gp] = 1'b0;
            end
        end
    endgenerate

    function automatic logic [31:0] mux_word(input logic [PFW-1:0] fn, input int k);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i < hub_strap_pkg::FIELDS_PER_MUX; i++) begin
            if (k * hub_strap_pkg::FIELDS_PER_MUX + i < hub_strap_pkg::NUM_PF) begin
                w[i*FW +: FW] = fn[(k * hub_strap_pkg::FIELDS_PER_MUX + i) * FW +: FW];
            end
        end
        return w;
    endfunction : mux_word

    always_comb begin
        logic access;
        logic hit;
        logic mux_hit;
        int k;
        logic [31:0] rd;
        access = req.psel && req.penable;
        mux_hit = req.paddr >= hub_strap_pkg::REG_PIN_MUX0 && req.paddr <= hub_strap_pkg::REG_PIN_MUX3
                  && req.paddr[1:0] == 2'h0;
        k = int'((req.paddr - hub_strap_pkg::REG_PIN_MUX0) >> 2);
        hit = mux_hit || req.paddr == hub_strap_pkg::REG_STATUS
              || req.paddr == hub_strap_pkg::REG_SETTINGS || req.paddr == hub_strap_pkg::REG_PORT_CTRL;
        rd = 32'h0000_0000;
        if (req.paddr == hub_strap_pkg::REG_STATUS) begin
            rd[hub_strap_pkg::ST_DPLUS_LSB +: 6] = st.dplus;
            rd[hub_strap_pkg::ST_DMINUS_LSB +: 6] = st.dminus;
            rd[hub_strap_pkg::ST_DIS_LSB +: 6] = st.port_dis;
            rd[hub_strap_pkg::ST_MODE_RSV_BIT] = st.mode_rsv;
            rd[hub_strap_pkg::ST_MIC_BIT] = st.mic;
        end else if (req.paddr == hub_strap_pkg::REG_SETTINGS) begin
            rd[hub_strap_pkg::SET_FIXED_LSB +: 6] = st.fixed_mask;
            rd[hub_strap_pkg::SET_CHARGE_LSB +: 6] = st.charge_mask;
            rd[hub_strap_pkg::SET_OC_LSB +: 6] = st.oc;
        end else if (req.paddr == hub_strap_pkg::REG_PORT_CTRL) begin
            rd[5:0] = st.host_dis;
        end else if (mux_hit) begin
            rd = mux_word(st.pin_fn, k);
        end

        next_st = st;
        next_st.capture = 1'b0;
        next_st.rsp.pready = 1'b0;
        next_st.rsp.pslverr = 1'b0;
        // the one-cycle wait keeps every bus output on a flop
        if (access && !st.rsp.pready) begin
            next_st.rsp.pready = 1'b1;
            next_st.rsp.pslverr = !hit;
            next_st.rsp.prdata = hit ? rd : 32'h0000_0000;
        end
        if (access && st.rsp.pready && req.pwrite && hit) begin
            if (req.paddr == hub_strap_pkg::REG_PORT_CTRL) begin
                next_st.host_dis = req.pwdata[5:0];
            end
            if (mux_hit) begin
                for (int i = 0; i < hub_strap_pkg::FIELDS_PER_MUX; i++) begin
                    if (k * hub_strap_pkg::FIELDS_PER_MUX + i < hub_strap_pkg::NUM_PF) begin
                        next_st.pin_fn[(k * hub_strap_pkg::FIELDS_PER_MUX + i) * FW +: FW] =
                            req.pwdata[i*FW +: FW];
                    end
                end
            end
        end

        // hold off until the external reset is released and pins have settled
        if (!ext_ok) begin
            next_st.pending = 1'b1;
            next_st.settle = 3'h0;
        end else if (st.pending) begin
            if (st.settle == 3'(SETTLE_CYCLES - 1)) begin
                next_st.pending = 1'b0;
                next_st.capture = 1'b1;
                next_st.dplus = dplus_s;
                next_st.dminus = dminus_s;
                next_st.port_dis = dplus_s & dminus_s;
                next_st.fixed_mask = hub_strap_pkg::level_mask(fixed_s);
                next_st.charge_mask = hub_strap_pkg::level_mask(charge_s);
                // only configuration 3 exists, so reserved patterns fall back to it
                next_st.mode_rsv = !(mode2_s == hub_strap_pkg::LVL_200K_DN
                                     && mode1_s == hub_strap_pkg::LVL_10K_DN);
                next_st.pin_fn = hub_strap_pkg::PF_DEFAULT;
            end else begin
                next_st.settle = st.settle + 3'h1;
            end
        end

        next_st.ss_dis = eff_dis;
        next_st.ctl_oe = eff_dis & ctl_fn_ok;
        next_st.ss_oe = eff_dis[4:2] & ss_fn_ok[4:2];
        // pins are unsettled while a latch is pending, so no overcurrent until the straps latch after each reset
        next_st.oc = ~eff_dis & ctl_fn_ok & ~ctl_n_s & {6{!st.pending}};
        next_st.mic = mic_s && st.pin_fn[MIC_OFS +: FW] == hub_strap_pkg::FN_MIC;
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
            st.pending <= 1'b1;
            st.host_dis <= hub_strap_pkg::HOST_DIS_RESET;
            st.pin_fn <= hub_strap_pkg::PF_DEFAULT;
        end else begin
            st <= next_st;
        end
    end

    assign prdata_out = st.rsp.prdata;
    assign pready_out = st.rsp.pready;
    assign pslverr_out = st.rsp.pslverr;
    assign port_power_control_out = 6'h00;
    assign port_power_control_oe_out = st.ctl_oe;
    assign superspeed_power_control_oe_out = st.ss_oe;
    assign port_disabled_out = st.port_dis;
    assign superspeed_disabled_out = st.ss_dis;
    assign fixed_port_mask_out = st.fixed_mask;
    assign charging_port_mask_out = st.charge_mask;
    assign overcurrent_out = st.oc;
    assign mode_reserved_out = st.mode_rsv;
    assign microphone_detect_out = st.mic;
    assign straps_latched_out = st.capture;
    assign pin_function_out = st.pin_fn;

    a_dplus_latch: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture |-> st.dplus == $past(dplus_s))
        else $error("dplus strap not latched");

    a_dminus_latch: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture |-> st.dminus == $past(dminus_s))
        else $error("dminus strap not latched");

    a_port_both_lines: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        port_disabled_out == (st.dplus & st.dminus))
        else $error("port disabled without both straps");

    a_superspeed_follows: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        ##1 superspeed_disabled_out == ($past(port_disabled_out) | $past(st.host_dis)))
        else $error("superspeed portion not disabled with port");

    a_fixed_level: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.pending && ext_ok && st.settle == 3'(SETTLE_CYCLES - 1)
        && fixed_s == hub_strap_pkg::LVL_10K_UP |=> fixed_port_mask_out == 6'h07)
        else $error("fixed port level decoded wrong");

    a_charge_lowest: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture && $past(charge_s) == hub_strap_pkg::LVL_200K_DN |-> charging_port_mask_out == 6'h00)
        else $error("charging left on at lowest level");

    a_mode_config3: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture |-> mode_reserved_out == !($past(mode2_s) == hub_strap_pkg::LVL_200K_DN
                                              && $past(mode1_s) == hub_strap_pkg::LVL_10K_DN))
        else $error("mode strap decode wrong");

    a_mux_override: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        psel_in && penable_in && pready_out && pwrite_in && paddr_in == hub_strap_pkg::REG_PIN_MUX0
        && !(st.pending && ext_ok && st.settle == 3'(SETTLE_CYCLES - 1))
        |=> pin_function_out[31:0] == $past(pwdata_in))
        else $error("pin mux write lost");

    a_latch_after_release: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        $rose(ext_ok) |-> ##[LAT_MIN:LAT_MAX] st.capture)
        else $error("straps not latched after reset release");

    a_power_drive_low: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        $rose(port_power_control_oe_out[0]) |-> $past(eff_dis[0]) && port_power_control_out[0] == 1'b0)
        else $error("port control pin driven without disable");

    a_settings_stable: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        !st.capture |-> $stable(fixed_port_mask_out) && $stable(charging_port_mask_out)
                        && $stable(port_disabled_out))
        else $error("decoded settings changed between resets");

    // checks on the latched settings
    a_port_only_both: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture |-> port_disabled_out == ($past(dplus_s) & $past(dminus_s)))
        else $error("port disable not the and of both straps");

    a_fixed_none: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture && $past(fixed_s) == hub_strap_pkg::LVL_200K_DN |-> fixed_port_mask_out == 6'h00)
        else $error("fixed port lowest level decoded wrong");

    a_fixed_all: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture && $past(fixed_s) == hub_strap_pkg::LVL_10R_UP |-> fixed_port_mask_out == 6'h3F)
        else $error("fixed port highest level decoded wrong");

    a_charge_two: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture && $past(charge_s) == hub_strap_pkg::LVL_10K_DN |-> charging_port_mask_out == 6'h03)
        else $error("charging two port level decoded wrong");

    a_charge_all: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture && $past(charge_s) == hub_strap_pkg::LVL_10R_UP |-> charging_port_mask_out == 6'h3F)
        else $error("charging highest level decoded wrong");

    a_pin_defaults: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture |-> pin_function_out == hub_strap_pkg::PF_DEFAULT)
        else $error("pin functions not reloaded at latch");

    a_mic_default: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture |-> pin_function_out[MIC_OFS +: FW] == hub_strap_pkg::FN_MIC)
        else $error("microphone pin default wrong");

    a_mode_fallback: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        st.capture && mode_reserved_out |-> pin_function_out == hub_strap_pkg::PF_DEFAULT)
        else $error("reserved mode did not fall back");

    a_no_latch_in_reset: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        !ext_ok |=> !st.capture)
        else $error("straps latched while chip reset held");

    // checks on the pins and the bus
    a_mux_readback: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        psel_in && penable_in && pready_out && !pwrite_in && paddr_in == hub_strap_pkg::REG_PIN_MUX0
        && !st.capture |-> prdata_out == pin_function_out[31:0])
        else $error("pin mux read back wrong");

    a_mic_absent: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        !mic_s |=> !microphone_detect_out)
        else $error("microphone reported without one");

    a_mic_present: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        mic_s && st.pin_fn[MIC_OFS +: FW] == hub_strap_pkg::FN_MIC |=> microphone_detect_out)
        else $error("plugged microphone not reported");

    a_oc_needs_low_pin: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        overcurrent_out[0] |-> !$past(ctl_n_s[0]))
        else $error("overcurrent without low control pin");

    a_host_write: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        psel_in && penable_in && pready_out && pwrite_in && paddr_in == hub_strap_pkg::REG_PORT_CTRL
        |=> st.host_dis == $past(pwdata_in[5:0]))
        else $error("host port disable write lost");

    a_ss_oe_disabled: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
        $rose(superspeed_power_control_oe_out[0]) |-> $past(eff_dis[2]))
        else $error("superspeed control driven without disable");
endmodule : hub_strap_decode

// [hdl/hub_strap_pkg.sv]
// constants, field layouts and carrier types for the strap decoder
package hub_strap_pkg;
    localparam int NUM_PORTS = 6;
    localparam int NUM_PF = 29;
    localparam int PF_FIRST = 3;
    localparam int FN_W = 4;
    localparam int LVL_W = 3;
    localparam int FIELDS_PER_MUX = 8;
    localparam int SETTLE_CYCLES = 4;
    localparam int MIC_PIN = 19;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_SETTINGS = 8'h04;
    localparam logic [7:0] REG_PORT_CTRL = 8'h08;
    localparam logic [7:0] REG_PIN_MUX0 = 8'h0C;
    localparam logic [7:0] REG_PIN_MUX3 = 8'h18;
    localparam int ST_DPLUS_LSB = 0;
    localparam int ST_DMINUS_LSB = 8;
    localparam int ST_DIS_LSB = 16;
    localparam int ST_MODE_RSV_BIT = 24;
    localparam int ST_MIC_BIT = 25;
    localparam int SET_FIXED_LSB = 0;
    localparam int SET_CHARGE_LSB = 8;
    localparam int SET_OC_LSB = 16;
    localparam logic [5:0] HOST_DIS_RESET = 6'h00;
    localparam logic [LVL_W-1:0] LVL_200K_DN = 3'h0;
    localparam logic [LVL_W-1:0] LVL_200K_UP = 3'h1;
    localparam logic [LVL_W-1:0] LVL_10K_DN = 3'h2;
    localparam logic [LVL_W-1:0] LVL_10K_UP = 3'h3;
    localparam logic [LVL_W-1:0] LVL_10R_DN = 3'h4;
    localparam logic [LVL_W-1:0] LVL_10R_UP = 3'h5;
    localparam logic [FN_W-1:0] FN_NC = 4'h0;
    localparam logic [FN_W-1:0] FN_AUD_SDI = 4'h1;
    localparam logic [FN_W-1:0] FN_AUD_SDO = 4'h2;
    localparam logic [FN_W-1:0] FN_AUD_SCK = 4'h3;
    localparam logic [FN_W-1:0] FN_AUD_LRCK = 4'h4;
    localparam logic [FN_W-1:0] FN_AUD_MCLK = 4'h5;
    localparam logic [FN_W-1:0] FN_POWER_CTL = 4'h6;
    localparam logic [FN_W-1:0] FN_BRIDGE_CLK = 4'h7;
    localparam logic [FN_W-1:0] FN_BRIDGE_LINE = 4'h8;
    localparam logic [FN_W-1:0] FN_MIC = 4'h9;
    localparam logic [FN_W-1:0] FN_SPI_CE = 4'hA;
    localparam logic [FN_W-1:0] FN_SPI_CLK = 4'hB;
    localparam logic [FN_W-1:0] FN_SPI_DATA = 4'hC;
    localparam logic [FN_W-1:0] FN_TGT_CLK = 4'hD;
    localparam logic [FN_W-1:0] FN_TGT_LINE = 4'hE;
    localparam logic [FN_W-1:0] FN_VBUS = 4'hF;
    // pin 31 down to pin 3
    localparam logic [NUM_PF*FN_W-1:0] PF_DEFAULT = {
        FN_BRIDGE_LINE, FN_VBUS, FN_NC, FN_POWER_CTL, FN_TGT_LINE, FN_TGT_CLK,
        FN_SPI_DATA, FN_SPI_DATA, FN_SPI_DATA, FN_SPI_DATA, FN_SPI_CLK, FN_SPI_CE,
        FN_MIC, FN_BRIDGE_CLK, {8{FN_POWER_CTL}}, FN_NC, FN_NC,
        FN_AUD_MCLK, FN_AUD_LRCK, FN_AUD_SCK, FN_AUD_SDO, FN_AUD_SDI};
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_type;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_type;
    // port 0-based to its power control pin number
    function automatic int power_pin(input int p);
        return (p == 5) ? 28 : 17 - p;
    endfunction : power_pin
    // ports 2..4 (0-based) own a superspeed control pin
    function automatic int ss_pin(input int p);
        return 8 + p;
    endfunction : ss_pin
    function automatic logic [5:0] level_mask(input logic [LVL_W-1:0] lvl);
        logic [5:0] m;
        unique case (lvl)
            LVL_200K_DN: m = 6'h00;
            LVL_200K_UP: m = 6'h01;
            LVL_10K_DN: m = 6'h03;
            LVL_10K_UP: m = 6'h07;
            LVL_10R_DN: m = 6'h0F;
            LVL_10R_UP: m = 6'h3F;
            default: m = 6'h00;
        endcase
        return m;
    endfunction : level_mask
endpackage : hub_strap_pkg

// [hdl/strap_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module strap_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sync_state_type;
    sync_state_type st;
    sync_state_type next_st;
    initial begin
        if (WIDTH < 1) $error("strap_sync needs WIDTH of at least 1");
    end
    always_comb begin
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // s1 feeds only s2; a change counts once s2 and s3 agree
        next_st.q = (st.s2 & st.s3) | (st.q & (st.s2 ^ st.s3));
    end
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign level_out = st.q;
endmodule : strap_sync

// [bench/board_loads.sv]
// board side model: port control pin loads and microphone jack
`timescale 1ns/10ps
module board_loads (
    input wire logic [5:0] drive_low_in,
    input wire logic [5:0] fault_in,
    input wire logic jack_in,
    output logic [5:0] pin_out,
    output logic mic_out
);
    // pull-up unless hub drives low or a current monitor pulls the line down
    assign pin_out = ~(drive_low_in | fault_in);
    assign mic_out = jack_in;
    // third mode strap sits 200k down on the board; the hub never reads it
endmodule : board_loads

// [bench/hub_strap_decode_tb.sv]
// self-checking bench for the strap decoder
`timescale 1ns/10ps
module hub_strap_decode_tb;
    localparam logic [115:0] PF_EXP = 116'h8F06EDCCCCBA97666666660054321;
    logic clk = 1'b0, nrst = 1'b0, chip_n = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mic = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, rsv, mic_out, latched, mic_lvl, err;
    logic [5:0] dp = 6'h00, dm = 6'h00, fault = 6'h00, pin;
    logic [2:0] fx = 3'h0, ch = 3'h0, m1 = 3'h2, m2 = 3'h0, ss_oe;
    logic [5:0] pc_out, pc_oe, dis, ss_dis, fmask, cmask, oc;
    logic [115:0] pfn;
    int mismatches = 0;
    int samples_checked = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    board_loads loads (.drive_low_in(pc_oe), .fault_in(fault), .jack_in(mic), .pin_out(pin), .mic_out(mic_lvl));
    hub_strap_decode #(.SETTLE_CYCLES(4)) dut (
        .core_clk_in(clk), .nrst_in(nrst), .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .chip_reset_n_in(chip_n), .port_dplus_disable_strap_in(dp),
        .port_dminus_disable_strap_in(dm), .fixed_port_count_strap_in(fx),
        .charging_port_count_strap_in(ch), .mode1_strap_in(m1), .mode2_strap_in(m2),
        .port_power_control_in(pin), .microphone_detect_in(mic_lvl), .port_power_control_out(pc_out),
        .port_power_control_oe_out(pc_oe), .superspeed_power_control_oe_out(ss_oe),
        .port_disabled_out(dis), .superspeed_disabled_out(ss_dis), .fixed_port_mask_out(fmask),
        .charging_port_mask_out(cmask), .overcurrent_out(oc), .mode_reserved_out(rsv),
        .microphone_detect_out(mic_out), .straps_latched_out(latched), .pin_function_out(pfn));
    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] exp_mask(input int l);
        return (l == 5) ? 32'h3F : (l > 5) ? 32'h0 : (32'h1 << l) - 32'h1;
    endfunction : exp_mask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            wrap_up();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb
    task automatic wait_latch();
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (latched !== 1'b1 && n < 40);
        if (n >= 40) begin
            mismatches++;
            wrap_up();
        end
    endtask : wait_latch
    task automatic chk_pfn();
        for (int k = 0; k < 4; k++) begin
            chk(32'(pfn >> 32 * k), 32'(PF_EXP >> 32 * k));
        end
    endtask : chk_pfn
    task automatic relatch(input logic [5:0] a, input logic [5:0] b, input logic [2:0] f, input logic [2:0] c,
        input logic [2:0] x);
        @(posedge clk);
        dp <= a;
        dm <= b;
        fx <= f;
        ch <= c;
        m1 <= x;
        chip_n <= 1'b0;
        repeat (6) @(posedge clk);
        chip_n <= 1'b1;
        wait_latch();
    endtask : relatch
    task automatic s_levels();
        for (int l = 0; l < 6; l++) begin
            relatch(6'h0F, 6'h3C, 3'(l), 3'(5 - l), 3'h2);
            chk(32'(fmask), exp_mask(l));
            chk(32'(cmask), exp_mask(5 - l));
            chk(32'(dis), 32'h0C);
            chk(32'(rsv), 32'h0);
            chk_pfn();
            @(posedge clk);
            chk(32'(ss_dis), 32'h0C);
            repeat (2) @(posedge clk);
            chk(32'(pc_oe), 32'h0C);
        end
        fx <= 3'h0;
        dp <= 6'h3F;
        dm <= 6'h3F;
        repeat (12) @(posedge clk);
        chk(32'(fmask), 32'h3F);
        chk(32'(dis), 32'h0C);
    endtask : s_levels
    task automatic s_reserved();
        relatch(6'h00, 6'h00, 3'h0, 3'h0, 3'h0);
        chk(32'(rsv), 32'h1);
        chk_pfn();
    endtask : s_reserved
    task automatic s_regs();
        relatch(6'h0F, 6'h3C, 3'h3, 3'h1, 3'h2);
        apb(8'h00, 1'b0, 32'h0);
        chk(rd, 32'h000C3C0F);
        apb(8'h04, 1'b1, 32'hFFFFFFFF);
        apb(8'h04, 1'b0, 32'h0);
        chk(rd, 32'h00000107);
        chk(32'(err), 32'h0);
        apb(8'h40, 1'b0, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(8'h08, 1'b1, 32'hFFFFFFFF);
        apb(8'h08, 1'b0, 32'h0);
        chk(rd, 32'h3F);
        repeat (3) @(posedge clk);
        chk({ss_oe, pc_oe, ss_dis, pc_out}, 32'h1FFFC0);
        apb(8'h08, 1'b1, 32'h0);
        apb(8'h0C, 1'b1, 32'h76543210);
        apb(8'h0C, 1'b0, 32'h0);
        chk(rd, 32'h76543210);
        chk(pfn[31:0], 32'h76543210);
        relatch(6'h0F, 6'h3C, 3'h3, 3'h1, 3'h2);
        chk_pfn();
    endtask : s_regs
    task automatic s_pins();
        @(posedge clk);
        fault <= 6'h3F;
        mic <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(oc), 32'h33);
        chk(32'(mic_out), 32'h1);
        apb(8'h00, 1'b0, 32'h0);
        chk(rd, 32'h020C3C0F);
        fault <= 6'h00;
        mic <= 1'b0;
        repeat (8) @(posedge clk);
        chk({oc, mic_out}, 32'h0);
    endtask : s_pins
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        wait_latch();
        s_levels();
        s_reserved();
        s_regs();
        s_pins();
        wrap_up();
    end
endmodule : hub_strap_decode_tb
